// ==== cpu_mode_access_firewall.sv ====
// CPU mode decoding and access firewall in front of RAM and SFRs
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_access_firewall
  import access_firewall_pkg::*;
(
  input  wire logic                                  clock_in,
  input  wire logic                                  rstn_in,
  input  wire access_firewall_pkg::access_req_t      req_in,
  input  wire logic                                  boot_bit_in,
  input  wire logic                                  test_bit_in,
  input  wire logic [access_firewall_pkg::CFG_W-1:0] fuse_in,
  output access_firewall_pkg::access_fwd_t           fwd_out,
  output logic                                       denied_out,
  output access_firewall_pkg::cpu_mode_t             mode_out,
  output logic [access_firewall_pkg::CFG_W-1:0]      blocks_enable_out,
  output logic [access_firewall_pkg::DATA_W-1:0]     fw_rdata_out
);
  import access_firewall_pkg::*;

  logic [DATA_W-1:0] status_word_high_q;
  logic [DATA_W-1:0] fw_regs_q [FW_REG_COUNT];
  logic [1:0]        boot_sync_q;
  logic [1:0]        test_sync_q;
  logic [1:0]        int_bits_q;
  logic [CFG_W-1:0]  prod_cfg;
  logic              cfg_loaded;
  logic              clos_enabled;
  cpu_mode_t         mode_d;
  logic              allow_d;
  logic              in_window;
  logic [ADDR_W-1:0] win_base;
  logic [ADDR_W-1:0] win_size;
  logic [ADDR_W:0]   win_end;
  logic [15:0]       fw_ctrl;
  logic              sfr_write_ok;

  // Production configuration store, loaded once after reset
  config_fuse_store u_cfg (
    .clock_in   (clock_in),
    .rstn_in    (rstn_in),
    .fuse_in    (fuse_in),
    .config_out (prod_cfg),
    .loaded_out (cfg_loaded)
  );

  // Internal mode bits come from pins, so they pass three flip-flops
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      boot_sync_q <= 2'h0;
      test_sync_q <= 2'h0;
      int_bits_q  <= 2'h0;
    end else begin
      boot_sync_q <= {boot_sync_q[0], boot_bit_in};
      test_sync_q <= {test_sync_q[0], test_bit_in};
      int_bits_q  <= {boot_sync_q[1], test_sync_q[1]};
    end
  end

  // Hardware-register index decode, used for access decisions and for checks
  function automatic logic is_hw_sfr(input logic [ADDR_W-1:0] a);
    return a[7:0] >= HW_SFR_FIRST;
  endfunction

  function automatic logic is_fw_sfr(input logic [ADDR_W-1:0] a);
    return (a[7:0] >= FW_SFR_FIRST) &&
           (a[7:0] < FW_SFR_FIRST + 8'(FW_REG_COUNT));
  endfunction

  // Mode decode from status word high and two internal bits
  always_comb begin
    if (int_bits_q[1]) begin
      mode_d = MODE_BOOT;
    end else if (int_bits_q[0]) begin
      mode_d = MODE_TEST;
    end else if (status_word_high_q[MODE_CLOS_BIT] && clos_enabled) begin
      mode_d = MODE_CLOS;
    end else if (status_word_high_q[MODE_SYS_BIT]) begin
      mode_d = MODE_SYSTEM;
    end else begin
      mode_d = MODE_APP;
    end
  end

  // Contactless mode exists only where the configuration enables it
  assign clos_enabled = cfg_loaded & prod_cfg[CFG_CLOS_EN_BIT];

  // Window and control assembled from the byte-wide firewall registers
  assign fw_ctrl  = {fw_regs_q[FW_CTRL_HI], fw_regs_q[FW_CTRL_LO]};
  assign win_base = {fw_regs_q[FW_BASE_HI], fw_regs_q[FW_BASE_LO]};
  assign win_size = {fw_regs_q[FW_SIZE_HI], fw_regs_q[FW_SIZE_LO]};
  assign win_end  = {1'b0, win_base} + {1'b0, win_size};
  // Window is [base, base+size); wider sum avoids wrap-around grants
  assign in_window = ({1'b0, req_in.addr} >= {1'b0, win_base}) &&
                     ({1'b0, req_in.addr} < win_end);

  // Only privileged, boot and test modes may change rights or the status word
  assign sfr_write_ok = (mode_d == MODE_SYSTEM) || (mode_d == MODE_BOOT) ||
                        (mode_d == MODE_TEST);

  // Access decision for the current request
  always_comb begin
    allow_d = 1'b0;
    if (!req_in.is_sfr) begin
      case (mode_d)
        MODE_BOOT, MODE_TEST: allow_d = 1'b1;
        MODE_SYSTEM, MODE_APP: allow_d = req_in.addr <= RAM_TOP;
        // Firewall grants only the window on top of nothing
        MODE_CLOS: allow_d = in_window;
        default: allow_d = 1'b0;
      endcase
    end else if (req_in.addr[7:0] == CONFIG_SFR) begin
      allow_d = !req_in.write;
    end else if (is_fw_sfr(req_in.addr) ||
                 req_in.addr[7:0] == STATUS_SFR) begin
      allow_d = !req_in.write || sfr_write_ok;
    end else if (is_hw_sfr(req_in.addr)) begin
      case (mode_d)
        MODE_APP: allow_d = |(req_in.app_grant &
                    (8'h01 << req_in.addr[2:0]));
        MODE_CLOS: allow_d = fw_ctrl[req_in.addr[3:0]];
        default: allow_d = 1'b1;
      endcase
    end else begin
      allow_d = 1'b1; // General CPU registers
    end
  end

  // Status word high: mode changes only from a permitted mode
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_word_high_q <= STATUS_RESET;
    end else if (req_in.valid && req_in.write && req_in.is_sfr &&
                 req_in.addr[7:0] == STATUS_SFR && allow_d) begin
      status_word_high_q <= req_in.wdata;
    end
  end

  // Firewall registers stay writable even when the mode is absent
  generate
    for (genvar i = 0; i < FW_REG_COUNT; i++) begin : g_fw
      always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
          fw_regs_q[i] <= FW_REG_RESET;
        end else if (req_in.valid && req_in.write && req_in.is_sfr &&
                     allow_d && req_in.addr[7:0] == FW_SFR_FIRST + 8'(i)) begin
          fw_regs_q[i] <= req_in.wdata;
        end
      end
    end
  endgenerate

  // Forwarded access; a refused one never reaches the target
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fwd_out    <= '0;
      denied_out <= 1'b0;
    end else begin
      fwd_out.valid  <= req_in.valid & allow_d;
      fwd_out.write  <= req_in.write & allow_d;
      fwd_out.is_sfr <= req_in.is_sfr;
      fwd_out.addr   <= req_in.addr;
      fwd_out.wdata  <= req_in.wdata;
      denied_out     <= req_in.valid & !allow_d;
    end
  end

  // Mode, configuration and firewall read-back outputs
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_out          <= MODE_BOOT;
      blocks_enable_out <= '0;
      fw_rdata_out      <= FW_REG_RESET;
    end else begin
      mode_out          <= mode_d;
      blocks_enable_out <= prod_cfg;
      if (is_fw_sfr(req_in.addr)) begin
        fw_rdata_out <= fw_regs_q[3'(req_in.addr[7:0] - FW_SFR_FIRST)];
      end else begin
        fw_rdata_out <= status_word_high_q;
      end
    end
  end

  // Refused requests never appear downstream
  no_refused_fwd_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && !allow_d) |=> (!fwd_out.valid && denied_out))
    else $error("refused access was forwarded");
  fwd_mirror_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && allow_d) |=> (fwd_out.valid && !denied_out &&
     fwd_out.addr == $past(req_in.addr) &&
     fwd_out.wdata == $past(req_in.wdata)))
    else $error("allowed access not forwarded intact");
  refused_write_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && req_in.write && !allow_d) |=> !fwd_out.write)
    else $error("refused write reached the target");
  deny_cause_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    denied_out |-> $past(req_in.valid))
    else $error("denial without a request");

  // RAM rights per mode; the window may only ever add access
  clos_ram_window_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && !req_in.is_sfr && mode_d == MODE_CLOS && !in_window)
    |=> denied_out)
    else $error("contactless access outside window allowed");
  clos_window_grant_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && !req_in.is_sfr && mode_d == MODE_CLOS && in_window)
    |=> fwd_out.valid)
    else $error("contactless access inside window refused");
  full_ram_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && !req_in.is_sfr && !clos_enabled &&
     req_in.addr <= RAM_TOP) |=> fwd_out.valid)
    else $error("RAM access refused without contactless mode");
  app_ram_top_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && !req_in.is_sfr && mode_d == MODE_APP &&
     req_in.addr > RAM_TOP) |=> denied_out)
    else $error("application reached memory above RAM");

  // Configuration is fixed once loaded and never writable by software
  cfg_fixed_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    cfg_loaded |=> $stable(prod_cfg))
    else $error("production configuration changed");
  cfg_write_block_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && req_in.write && req_in.is_sfr &&
     req_in.addr[7:0] == CONFIG_SFR) |=> denied_out)
    else $error("configuration write was not refused");
  blocks_mirror_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    cfg_loaded |=> blocks_enable_out == $past(prod_cfg))
    else $error("block enables differ from configuration");

  // Register rights; the status address sits inside the hardware range,
  // so the hardware checks leave it out, its own check wins there
  app_no_psw_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && req_in.write && req_in.is_sfr && mode_d == MODE_APP &&
     req_in.addr[7:0] == STATUS_SFR) |=> $stable(status_word_high_q))
    else $error("application changed status word");
  fw_reg_guard_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && req_in.write && req_in.is_sfr &&
     is_fw_sfr(req_in.addr) &&
     (mode_d == MODE_APP || mode_d == MODE_CLOS)) |=> denied_out)
    else $error("unprivileged firewall register write allowed");
  fw_reg_land_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && req_in.write && req_in.is_sfr &&
     req_in.addr[7:0] == FW_SFR_FIRST + 8'(FW_BASE_HI) &&
     mode_d != MODE_APP && mode_d != MODE_CLOS)
    |=> fw_regs_q[FW_BASE_HI] == $past(req_in.wdata))
    else $error("privileged firewall register write lost");
  app_grant_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && req_in.is_sfr && mode_d == MODE_APP &&
     is_hw_sfr(req_in.addr) && req_in.addr[7:0] != STATUS_SFR &&
     req_in.app_grant == 8'h00) |=> denied_out)
    else $error("ungranted application hardware access");
  clos_sfr_ctrl_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && req_in.is_sfr && mode_d == MODE_CLOS &&
     is_hw_sfr(req_in.addr) && req_in.addr[7:0] != STATUS_SFR &&
     !fw_ctrl[req_in.addr[3:0]]) |=> denied_out)
    else $error("contactless hardware access not blocked");
  clos_hw_grant_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (req_in.valid && req_in.is_sfr && mode_d == MODE_CLOS &&
     is_hw_sfr(req_in.addr) && req_in.addr[7:0] != STATUS_SFR &&
     fw_ctrl[req_in.addr[3:0]]) |=> fwd_out.valid)
    else $error("granted contactless hardware access refused");

  // Mode decode priorities
  no_clos_mode_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    !clos_enabled |-> mode_d != MODE_CLOS)
    else $error("contactless mode active while disabled");
  boot_mode_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    int_bits_q[1] |=> mode_out == MODE_BOOT)
    else $error("boot bit did not select boot mode");
  test_mode_a: assert property (@(posedge clock_in)
    disable iff (!rstn_in)
    (!int_bits_q[1] && int_bits_q[0]) |=> mode_out == MODE_TEST)
    else $error("test bit did not select test mode");

  // Main scenarios worth seeing at least once
  clos_cov_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.valid && mode_d == MODE_CLOS && in_window);
  deny_cov_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    denied_out);
  app_cov_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.valid && mode_d == MODE_APP && req_in.is_sfr && allow_d);
  fused_cov_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.valid && !clos_enabled && mode_d == MODE_SYSTEM);
  status_cov_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.valid && req_in.write && req_in.is_sfr &&
    req_in.addr[7:0] == STATUS_SFR && allow_d);
endmodule
`default_nettype wire

// ==== access_firewall_pkg.sv ====
// Package with constants and carrier types for the CPU mode access firewall
package access_firewall_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int SFR_W  = 8;

  // Mode bits within the status word high register
  localparam int MODE_SYS_BIT  = 7;
  localparam int MODE_CLOS_BIT = 6;

  // Firewall register indices in the firewall register file
  localparam logic [2:0] FW_CTRL_LO   = 3'h0;
  localparam logic [2:0] FW_CTRL_HI   = 3'h1;
  localparam logic [2:0] FW_BASE_LO   = 3'h2;
  localparam logic [2:0] FW_BASE_HI   = 3'h3;
  localparam logic [2:0] FW_SIZE_LO   = 3'h4;
  localparam logic [2:0] FW_SIZE_HI   = 3'h5;
  localparam int         FW_REG_COUNT = 6;

  // Values after reset
  localparam logic [DATA_W-1:0] FW_REG_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RESET   = 8'h00;

  // Address map: SFR space above RAM, hardware SFRs in the upper quarter
  localparam logic [ADDR_W-1:0] RAM_TOP        = 16'h7FFF;
  localparam logic [7:0]        HW_SFR_FIRST   = 8'hC0;
  localparam logic [7:0]        FW_SFR_FIRST   = 8'hA0;
  localparam logic [7:0]        STATUS_SFR     = 8'hD0;
  localparam logic [7:0]        CONFIG_SFR     = 8'hA8;

  // Production configuration bit positions
  localparam int CFG_CLOS_EN_BIT = 0;
  localparam int CFG_W           = 8;

  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_TEST,
    MODE_CLOS,
    MODE_SYSTEM,
    MODE_APP
  } cpu_mode_t;

  // One access issued by the core
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              is_sfr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [SFR_W-1:0]  app_grant;
  } access_req_t;

  // Access forwarded to memory or registers
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              is_sfr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } access_fwd_t;

endpackage

// ==== config_fuse_store.sv ====
// One-time production configuration latch, fixed after first load
`timescale 1ns/1ps
`default_nettype none
module config_fuse_store
  import access_firewall_pkg::*;
(
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  input  wire logic [CFG_W-1:0] fuse_in,
  output logic      [CFG_W-1:0] config_out,
  output logic                  loaded_out
);
  import access_firewall_pkg::*;

  logic [CFG_W-1:0] fuse_meta_q;
  logic [CFG_W-1:0] fuse_sync_q;
  logic [1:0]       fill_q;

  // Fuse pins are static but not clocked, so two flops come first
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fuse_meta_q <= '0;
      fuse_sync_q <= '0;
      fill_q      <= 2'h0;
    end else begin
      fuse_meta_q <= fuse_in;
      fuse_sync_q <= fuse_meta_q;
      fill_q      <= {fill_q[0], 1'b1}; // Marks the sync stage as filled
    end
  end

  // Captured once after reset release; no software path reaches it
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      config_out <= '0;
      loaded_out <= 1'b0;
    end else if (!loaded_out && fill_q[1]) begin
      config_out <= fuse_sync_q;
      loaded_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== cpu_core_model.sv ====
// Core-side model that issues accesses into the firewall
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
  import access_firewall_pkg::*;
(
  input  wire logic  clock_in,
  output var access_req_t req_out
);
  initial req_out = '0;

  // New access launched just after an edge, held until the answer edge
  task automatic issue(input access_req_t r);
    @(posedge clock_in);
    req_out <= r;
  endtask

  // Idle bus scrambles its fields so a stale copy never looks valid
  task automatic idle();
    access_req_t t;
    t = ~req_out;
    t.valid = 1'b0;
    req_out <= t;
  endtask
endmodule
`default_nettype wire

// ==== cpu_mode_access_firewall_test.sv ====
// Self-checking bench for the CPU mode access firewall
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_access_firewall_test;
  import access_firewall_pkg::*;
  logic              clock_in = 1'b0;
  logic              rstn_in  = 1'b0;
  logic              boot_bit = 1'b0;
  logic              test_bit = 1'b0;
  logic [CFG_W-1:0]  fuse     = 8'h00;
  access_req_t       req;
  access_fwd_t       fwd;
  logic              denied;
  cpu_mode_t         mode;
  logic [CFG_W-1:0]  blocks;
  logic [DATA_W-1:0] rdata;
  int                fail_count   = 0;
  int                total_checks = 0;
  int                cycles       = 0;

  always #5 clock_in = ~clock_in;

  cpu_core_model core (.clock_in(clock_in), .req_out(req));

  cpu_mode_access_firewall uut (
    .clock_in          (clock_in),
    .rstn_in           (rstn_in),
    .req_in            (req),
    .boot_bit_in       (boot_bit),
    .test_bit_in       (test_bit),
    .fuse_in           (fuse),
    .fwd_out           (fwd),
    .denied_out        (denied),
    .mode_out          (mode),
    .blocks_enable_out (blocks),
    .fw_rdata_out      (rdata)
  );

  task automatic check(input string w, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Reset for 8 cycles, then wait until mode bits have settled
  task automatic restart(input logic [7:0] f, input logic b, t);
    @(posedge clock_in);
    rstn_in <= 1'b0;
    fuse <= f;
    boot_bit <= b;
    test_bit <= t;
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
  endtask

  // Internal bits pass three sync flops, so give them time to land
  task automatic bits(input logic b, t);
    @(posedge clock_in);
    boot_bit <= b;
    test_bit <= t;
    repeat (5) @(posedge clock_in);
    #1;
  endtask

  // f = {write, sfr, expected allow}; answer comes exactly one edge later
  task automatic access(input logic [2:0] f, input logic [15:0] a,
                        input logic [7:0] d, g);
    core.issue({1'b1, f[2], f[1], a, d, g});
    @(posedge clock_in);
    core.idle();
    #1;
    check("fwd valid", 16'(fwd.valid), 16'(f[0]));
    check("denied", 16'(denied), 16'(!f[0]));
    check("fwd write", 16'(fwd.write), 16'(f[2] & f[0]));
    if (f[0]) check("fwd addr", fwd.addr, a);
    if (f[0]) check("fwd data", 16'(fwd.wdata), 16'(d));
    if (f[0]) check("fwd sfr", 16'(fwd.is_sfr), 16'(f[1]));
  endtask

  task automatic mode_is(input cpu_mode_t m);
    check("mode", 16'(mode), 16'(m));
  endtask

  // Boot sets up a window 0x1000..0x100F and hardware rights 0 and 2
  task automatic boot_setup();
    restart(8'h01, 1'b1, 1'b0);
    mode_is(MODE_BOOT);
    access(3'b111, 16'h00A0, 8'h05, 8'h00);
    access(3'b111, 16'h00A3, 8'h10, 8'h00);
    access(3'b111, 16'h00A4, 8'h10, 8'h00);
    access(3'b011, 16'h00A3, 8'h00, 8'h00);
    check("fw read", 16'(rdata), 16'h0010);
    access(3'b110, 16'h00A8, 8'hFF, 8'h00);
    @(posedge clock_in);
    fuse <= 8'hFE;
    repeat (4) @(posedge clock_in);
    #1;
    check("blocks", 16'(blocks), 16'h0001);
    access(3'b111, 16'h00D0, 8'h40, 8'h00);
    bits(1'b0, 1'b0);
    mode_is(MODE_CLOS);
  endtask

  task automatic clos_rules();
    access(3'b001, 16'h1000, 8'h00, 8'h00);
    access(3'b101, 16'h100F, 8'h5A, 8'h00);
    access(3'b000, 16'h1010, 8'h00, 8'h00);
    access(3'b000, 16'h0FFF, 8'h00, 8'h00);
    access(3'b011, 16'h00C0, 8'h00, 8'h00);
    access(3'b010, 16'h00C1, 8'h00, 8'h00);
    access(3'b011, 16'h00C2, 8'h00, 8'h00);
    access(3'b110, 16'h00A0, 8'hFF, 8'h00);
    access(3'b011, 16'h00A0, 8'h00, 8'h00);
    check("fw read", 16'(rdata), 16'h0005);
    access(3'b110, 16'h00D0, 8'h80, 8'h00);
    mode_is(MODE_CLOS);
    access(3'b011, 16'h00D0, 8'h00, 8'h00);
    check("status", 16'(rdata), 16'h0040);
  endtask

  task automatic app_rules();
    restart(8'h01, 1'b1, 1'b0);
    bits(1'b0, 1'b0);
    mode_is(MODE_APP);
    access(3'b011, 16'h00C3, 8'h00, 8'h08);
    access(3'b010, 16'h00C3, 8'h00, 8'hF7);
    access(3'b001, 16'h7FFF, 8'h00, 8'h00);
    access(3'b000, 16'h8000, 8'h00, 8'h00);
    access(3'b110, 16'h00D0, 8'h80, 8'h00);
    mode_is(MODE_APP);
    access(3'b011, 16'h00D0, 8'h00, 8'h00);
    check("status", 16'(rdata), 16'h0000);
  endtask

  // Contactless mode fused off: window and status bit 6 do nothing
  task automatic fused_off_rules();
    restart(8'h00, 1'b0, 1'b1);
    mode_is(MODE_TEST);
    check("blocks", 16'(blocks), 16'h0000);
    access(3'b111, 16'h00A3, 8'h20, 8'h00);
    access(3'b111, 16'h00D0, 8'hC0, 8'h00);
    bits(1'b0, 1'b0);
    mode_is(MODE_SYSTEM);
    access(3'b001, 16'h0000, 8'h00, 8'h00);
    access(3'b001, 16'h7FFF, 8'h00, 8'h00);
    access(3'b011, 16'h00A3, 8'h00, 8'h00);
    check("fw read", 16'(rdata), 16'h0020);
    access(3'b111, 16'h00D0, 8'h40, 8'h00);
    repeat (2) @(posedge clock_in);
    #1;
    mode_is(MODE_APP);
    access(3'b001, 16'h2000, 8'h00, 8'h00);
  endtask

  // Hang guard: the whole run needs well under 5000 cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    boot_setup();
    clos_rules();
    app_rules();
    fused_off_rules();
    close_out();
  end
endmodule
`default_nettype wire
